//--- verif/phr_host.sv
// Purpose: host model issuing register port requests
// Assumes: one request at a time, driven 1 ns after the rising edge
// Notes:   idle address and data lines show the inverse of the last value
`timescale 1ns/1ns
module phr_host
(
  input  wire logic        clk,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  output logic             wr_en,
  output logic             rd_en,
  output logic [6:0]       addr,
  output logic [15:0]      wdata
);
  // idle bus at time zero
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 7'h00;
    wdata = 16'h0000;
  end

  // one write, wr_en high for one edge
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk);
    #1;
    wr_en = 1'b0;
    addr  = ~a;
    wdata = ~d;
  endtask

  // one read, answer taken one edge later
  task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    #1;
    addr  = a;
    rd_en = 1'b1;
    @(posedge clk);
    #1;
    rd_en = 1'b0;
    addr  = ~a;
    v     = rd_valid;
    d     = rd_data;
  endtask
endmodule

//--- verif/phr_regs_assertions.sv
// Purpose: port-level checks of the power, hysteresis and reset register bank
// Assumes: one clock domain, reset active low and synchronous
// Notes:   write checks need hw_rst_n high for six edges, the last of them at the write
`timescale 1ns/1ns
module phr_regs_assertions
#(
  parameter logic [15:0] ID_VALUE = phr_pkg::ID_CODE, // arbitrary value
  parameter int          N_DAC    = phr_pkg::NUM_DAC
)
(
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             ce,
  input wire logic             hw_rst_n,
  input wire logic             i2c_mode,
  input wire logic             wr_en,
  input wire logic             rd_en,
  input wire logic [6:0]       addr,
  input wire logic [15:0]      wdata,
  input wire logic [15:0]      rd_data,
  input wire logic             rd_valid,
  input wire logic             converter_active,
  input wire logic             refbuf_active,
  input wire logic [N_DAC-1:0] dac_channel_active,
  input wire logic [N_DAC-1:0] dac_out_grounded,
  input wire logic [7:0]       remote2_hyst,
  input wire logic [7:0]       remote1_hyst,
  input wire logic [7:0]       local_temp_hyst,
  input wire logic             soft_reset_pulse
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // dac enable bits run downwards from bit 12
  function automatic logic [N_DAC-1:0] dac_map(input logic [15:0] w);
    for (int i = 0; i < N_DAC; i++)
      dac_map[i] = w[phr_pkg::PWR_DAC0_BIT - i];
  endfunction

  // a taken register write, then one running edge for the outputs
  sequence reg_wr(a);
    hw_rst_n[*6] ##0 (ce && wr_en && addr == a) ##1 ce;
  endsequence
  // a taken write to the reset register in the given mode
  sequence srst_wr(m);
    (hw_rst_n && i2c_mode == m)[*6] ##0 (ce && wr_en && addr == 7'h7C) ##1 ce;
  endsequence

  chk_read_answer: assert property (ce && rd_en |=> rd_valid)
    else $error("read not answered");
  chk_valid_cause: assert property (rd_valid && $past(ce) |-> $past(rd_en))
    else $error("stray read strobe");
  chk_id_value: assert property (ce && rd_en && addr == 7'h6C |=> rd_data == ID_VALUE)
    else $error("identifier wrong");
  chk_unmapped_zero: assert property (ce && rd_en && !(addr inside {7'h6A, 7'h6B, 7'h6C})
    |=> rd_data == 16'h0000) else $error("unmapped read not zero");
  chk_ground_inverse: assert property (dac_out_grounded == ~dac_channel_active)
    else $error("ground switch wrong");
  chk_hyst_frac: assert property ({remote2_hyst[2:0], remote1_hyst[2:0],
    local_temp_hyst[2:0]} == 9'h000) else $error("hysteresis low bits set");
  chk_power_map: assert property (reg_wr(7'h6B) |=> converter_active == $past(wdata[14], 2)
    && refbuf_active == $past(wdata[13], 2) && dac_channel_active == dac_map($past(wdata, 2)))
    else $error("power outputs wrong");
  chk_hyst_map: assert property (reg_wr(7'h6A) |=> remote2_hyst == {$past(wdata[14:10], 2), 3'b000}
    && remote1_hyst == {$past(wdata[9:5], 2), 3'b000}
    && local_temp_hyst == {$past(wdata[4:0], 2), 3'b000}) else $error("hysteresis outputs wrong");
  chk_spi_key: assert property (srst_wr(1'b0) |-> ##1 soft_reset_pulse == ($past(wdata, 2) == 16'h6600))
    else $error("spi reset key wrong");
  chk_i2c_any: assert property (srst_wr(1'b1) |-> ##1 soft_reset_pulse)
    else $error("i2c reset missed");
  chk_soft_defaults: assert property (soft_reset_pulse && ce |=> remote2_hyst == 8'h40
    && remote1_hyst == 8'h40 && local_temp_hyst == 8'h40 && !converter_active
    && !refbuf_active && dac_channel_active == '0) else $error("soft reset defaults wrong");
  chk_pulse_single: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("reset pulse too long");
endmodule

bind phr_regs phr_regs_assertions #(.ID_VALUE(ID_VALUE), .N_DAC(N_DAC)) i_phr_regs_assertions
  (.clk, .rst_n, .ce, .hw_rst_n, .i2c_mode, .wr_en, .rd_en, .addr, .wdata, .rd_data, .rd_valid,
   .converter_active, .refbuf_active, .dac_channel_active, .dac_out_grounded,
   .remote2_hyst, .remote1_hyst, .local_temp_hyst, .soft_reset_pulse);

//--- verif/phr_regs_tb.sv
// Purpose: self-checking bench of the power, hysteresis and reset registers
// Assumes: host model drives the register port
// Notes:   expected values come from the register layout only
`timescale 1ns/1ns
module phr_regs_tb;
  logic        clk, rst_n, ce, hw_rst_n, i2c_mode, wr_en, rd_en, rd_valid;
  logic        converter_active, refbuf_active, soft_reset_pulse, dac_regs_reset;
  logic [6:0]  addr;
  logic [15:0] wdata, rd_data;
  logic [11:0] dac_channel_active, dac_out_grounded;
  logic [7:0]  remote2_hyst, remote1_hyst, local_temp_hyst;
  int          err_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  phr_regs i_phr_regs (.clk, .rst_n, .ce, .hw_rst_n, .i2c_mode, .wr_en, .rd_en, .addr,
    .wdata, .rd_data, .rd_valid, .converter_active, .refbuf_active, .dac_channel_active,
    .dac_out_grounded, .remote2_hyst, .remote1_hyst, .local_temp_hyst, .soft_reset_pulse,
    .dac_regs_reset);
  phr_host i_phr_host (.clk, .rd_data, .rd_valid, .wr_en, .rd_en, .addr, .wdata);

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude;
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // read one register and compare
  task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    i_phr_host.rd(a, d, v);
    chk({15'h0000, v}, 16'h0001);
    chk(d, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      conclude();
    end
  end

  // main sequence
  initial
  begin
    logic [15:0] d;
    logic        v;
    rst_n    = 1'b0;
    ce       = 1'b1;
    hw_rst_n = 1'b1;
    i2c_mode = 1'b0;
    idle(10);
    rst_n = 1'b1;
    rchk(7'h6A, 16'h2108);
    rchk(7'h6B, 16'h0000);
    rchk(7'h6C, phr_pkg::ID_CODE);
    chk({remote2_hyst, local_temp_hyst}, 16'h4040);
    chk({4'h0, dac_out_grounded}, 16'h0FFF);
    i_phr_host.wr(7'h6A, 16'hFFFF);
    rchk(7'h6A, 16'h7FFF);
    chk({remote2_hyst, local_temp_hyst}, 16'hF8F8);
    i_phr_host.wr(7'h6A, 16'h0443);
    rchk(7'h6A, 16'h0443);
    chk({remote2_hyst, remote1_hyst}, 16'h0810);
    chk({8'h00, local_temp_hyst}, 16'h0018);
    for (int i = 0; i < 12; i++)
    begin
      i_phr_host.wr(7'h6B, 16'h0001 << (12 - i));
      idle(2);
      chk({4'h0, dac_channel_active}, 16'h0001 << i);
      chk({4'h0, dac_out_grounded}, 16'h0FFF & ~(16'h0001 << i));
    end
    i_phr_host.wr(7'h6B, 16'hFFFF);
    rchk(7'h6B, 16'h7FFE);
    chk({14'h0000, converter_active, refbuf_active}, 16'h0003);
    ce = 1'b0;
    i_phr_host.wr(7'h6B, 16'h0000);
    ce = 1'b1;
    rchk(7'h6B, 16'h7FFE);
    i_phr_host.wr(7'h6C, 16'h0000);
    rchk(7'h6C, phr_pkg::ID_CODE);
    rchk(7'h10, 16'h0000);
    rchk(7'h7C, 16'h0000);
    i_phr_host.wr(7'h7C, 16'h6601);
    idle(1);
    chk({15'h0000, soft_reset_pulse}, 16'h0000);
    idle(2);
    rchk(7'h6B, 16'h7FFE);
    i_phr_host.wr(7'h7C, 16'h6600);
    idle(1);
    chk({15'h0000, soft_reset_pulse}, 16'h0001);
    idle(2);
    chk({4'h0, dac_channel_active}, 16'h0000);
    rchk(7'h6A, 16'h2108);
    rchk(7'h6B, 16'h0000);
    chk({15'h0000, dac_regs_reset}, 16'h0000);
    i2c_mode = 1'b1;
    idle(4);
    i_phr_host.wr(7'h6B, 16'hFFFF);
    i_phr_host.wr(7'h7C, 16'h00A5);
    idle(3);
    rchk(7'h6B, 16'h0000);
    i_phr_host.rd(7'h7C, d, v);
    chk({15'h0000, v}, 16'h0001);
    i_phr_host.wr(7'h6B, 16'hFFFF);
    hw_rst_n = 1'b0;
    idle(6);
    chk({15'h0000, dac_regs_reset}, 16'h0001);
    hw_rst_n = 1'b1;
    idle(8);
    rchk(7'h6B, 16'h0000);
    chk({15'h0000, dac_regs_reset}, 16'h0000);
    chk({14'h0000, converter_active, refbuf_active}, 16'h0000);
    conclude();
  end
endmodule

//--- verilog/phr_ctrl_if.sv
// Purpose: carrier between the register bank and its reset helpers
// Assumes: one clock domain
// Notes:   write strobe fans out to the key decoder
`timescale 1ns/1ns
interface phr_ctrl_if;
  logic        wr_en;
  logic [6:0]  addr;
  logic [15:0] wdata;
  logic        i2c_mode;
  logic        soft_hit;
  logic        hw_low;
  logic        all_clear;
  logic        dac_clear;

  modport top    (output wr_en, addr, wdata, i2c_mode, hw_low,
                  input  soft_hit, all_clear, dac_clear);
  modport decode (input  wr_en, addr, wdata, i2c_mode,
                  output soft_hit);
  modport rstctl (input  soft_hit, hw_low,
                  output all_clear, dac_clear);
endinterface

//--- verilog/phr_pkg.sv
// Purpose: shared constants for the power, hysteresis and reset register bank
// Assumes: 16-bit registers behind a decoded serial-port access port
// Notes:   every offset, field position, reset value and key is named here once
package phr_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] OFF_HYST = 7'h6A;
  localparam logic [6:0] OFF_PWR  = 7'h6B;
  localparam logic [6:0] OFF_ID   = 7'h6C;
  localparam logic [6:0] OFF_SRST = 7'h7C;

  // ----------------------------------------------------------------
  // hysteresis layout and reset value
  // ----------------------------------------------------------------
  localparam int          HYST_FLD_W   = 5;
  localparam int          HYST_FRAC_W  = 3;
  localparam int          HYST_R2_LSB  = 10;
  localparam int          HYST_R1_LSB  = 5;
  localparam int          HYST_LT_LSB  = 0;
  localparam logic [15:0] HYST_RST     = 16'h2108;
  localparam logic [15:0] HYST_WMASK   = 16'h7FFF;

  // ----------------------------------------------------------------
  // power control layout and reset value
  // ----------------------------------------------------------------
  localparam int          NUM_DAC      = 12;
  localparam int          PWR_ADC_BIT  = 14;
  localparam int          PWR_REF_BIT  = 13;
  localparam int          PWR_DAC0_BIT = 12;
  localparam logic [15:0] PWR_RST      = 16'h0000;
  localparam logic [15:0] PWR_WMASK    = 16'h7FFE;

  // ----------------------------------------------------------------
  // identifier and soft reset
  // ----------------------------------------------------------------
  localparam logic [15:0] ID_CODE      = 16'h5A31; // arbitrary value
  localparam logic [15:0] SRST_SPI_KEY = 16'h6600;
  localparam logic [15:0] SRST_RD_VAL  = 16'h0000;

  // ----------------------------------------------------------------
  // reset sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    PHR_RUN  = 3'b001,
    PHR_SOFT = 3'b010,
    PHR_HARD = 3'b100
  } phr_rst_state_t;

endpackage

//--- verilog/phr_regs.sv
// Purpose: power control, hysteresis, identifier and soft reset registers
// Assumes: access port driven by serial-port logic on clk
// Notes:   hw_rst_n and i2c_mode are pins and pass two flip-flops
`timescale 1ns/1ns
module phr_regs
#(
  parameter logic [15:0] ID_VALUE = phr_pkg::ID_CODE, // arbitrary value
  parameter int          N_DAC    = phr_pkg::NUM_DAC
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              hw_rst_n,
  input  wire logic              i2c_mode,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [6:0]        addr,
  input  wire logic [15:0]       wdata,
  output logic      [15:0]       rd_data,
  output logic                   rd_valid,
  output logic                   converter_active,
  output logic                   refbuf_active,
  output logic      [N_DAC-1:0]  dac_channel_active,
  output logic      [N_DAC-1:0]  dac_out_grounded,
  output logic      [7:0]        remote2_hyst,
  output logic      [7:0]        remote1_hyst,
  output logic      [7:0]        local_temp_hyst,
  output logic                   soft_reset_pulse,
  output logic                   dac_regs_reset
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0]  hw_sync_q;
  logic [1:0]  mode_sync_q;
  logic [15:0] hyst_q;
  logic [15:0] pwr_q;
  logic [15:0] rd_d;
  logic        hyst_wr;
  logic        pwr_wr;

  phr_ctrl_if cif ();

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two stages each, second stage is the only reader of the first
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hw_sync_q   <= 2'h3;
      mode_sync_q <= 2'h0;
    end
    else if (ce)
    begin
      hw_sync_q   <= {hw_sync_q[0], hw_rst_n};
      mode_sync_q <= {mode_sync_q[0], i2c_mode};
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  assign cif.wr_en    = wr_en;
  assign cif.addr     = addr;
  assign cif.wdata    = wdata;
  assign cif.i2c_mode = mode_sync_q[1];
  assign cif.hw_low   = ~hw_sync_q[1];

  phr_srst_decode u_dec
  (
    .bus (cif.decode)
  );

  phr_rst_seq u_seq
  (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .bus   (cif.rstctl)
  );

  // writes are dropped while a clear is in progress
  assign hyst_wr = wr_en && (addr == phr_pkg::OFF_HYST) && !cif.all_clear;
  assign pwr_wr  = wr_en && (addr == phr_pkg::OFF_PWR) && !cif.all_clear;

  // ----------------------------------------------------------------
  // hysteresis register
  // ----------------------------------------------------------------
  // only 5-bit fields stored, bit 15 never written
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hyst_q <= phr_pkg::HYST_RST;
    else if (ce && cif.all_clear)
      hyst_q <= phr_pkg::HYST_RST;
    else if (ce && hyst_wr)
      hyst_q <= wdata & phr_pkg::HYST_WMASK;
  end

  // ----------------------------------------------------------------
  // power control register
  // ----------------------------------------------------------------
  // bits 15 and 0 never written
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pwr_q <= phr_pkg::PWR_RST;
    else if (ce && cif.all_clear)
      pwr_q <= phr_pkg::PWR_RST;
    else if (ce && pwr_wr)
      pwr_q <= wdata & phr_pkg::PWR_WMASK;
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // unmapped offsets read zero
  always_comb
  begin
    rd_d = 16'h0000;
    case (addr)
      phr_pkg::OFF_HYST: rd_d = hyst_q;
      phr_pkg::OFF_PWR:  rd_d = pwr_q;
      phr_pkg::OFF_ID:   rd_d = ID_VALUE;
      phr_pkg::OFF_SRST: rd_d = phr_pkg::SRST_RD_VAL;
      default:           rd_d = 16'h0000;
    endcase
  end

  // answer one cycle after the request
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end
    else if (ce)
    begin
      rd_valid <= rd_en;
      if (rd_en)
        rd_data <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // block enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      converter_active <= 1'b0;
      refbuf_active    <= 1'b0;
    end
    else if (ce)
    begin
      converter_active <= pwr_q[phr_pkg::PWR_ADC_BIT];
      refbuf_active    <= pwr_q[phr_pkg::PWR_REF_BIT];
    end
  end

  // one enable and one ground switch per DAC, DAC0 at the top bit
  for (genvar i = 0; i < N_DAC; i++)
  begin : g_dac
    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        dac_channel_active[i] <= 1'b0;
        dac_out_grounded[i]   <= 1'b1;
      end
      else if (ce)
      begin
        dac_channel_active[i] <= pwr_q[phr_pkg::PWR_DAC0_BIT - i];
        dac_out_grounded[i]   <= ~pwr_q[phr_pkg::PWR_DAC0_BIT - i];
      end
    end
  end

  // ----------------------------------------------------------------
  // hysteresis outputs
  // ----------------------------------------------------------------
  // full 8-bit value, low three bits forced zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      remote2_hyst    <= {phr_pkg::HYST_RST[14:10], 3'h0};
      remote1_hyst    <= {phr_pkg::HYST_RST[9:5], 3'h0};
      local_temp_hyst <= {phr_pkg::HYST_RST[4:0], 3'h0};
    end
    else if (ce)
    begin
      remote2_hyst    <= {hyst_q[phr_pkg::HYST_R2_LSB +: phr_pkg::HYST_FLD_W],
                          {phr_pkg::HYST_FRAC_W{1'b0}}};
      remote1_hyst    <= {hyst_q[phr_pkg::HYST_R1_LSB +: phr_pkg::HYST_FLD_W],
                          {phr_pkg::HYST_FRAC_W{1'b0}}};
      local_temp_hyst <= {hyst_q[phr_pkg::HYST_LT_LSB +: phr_pkg::HYST_FLD_W],
                          {phr_pkg::HYST_FRAC_W{1'b0}}};
    end
  end

  // ----------------------------------------------------------------
  // reset indications to the DAC and other register banks
  // ----------------------------------------------------------------
  // DAC data, latch and clear are spared by a soft reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      soft_reset_pulse <= 1'b0;
      dac_regs_reset   <= 1'b1;
    end
    else if (ce)
    begin
      soft_reset_pulse <= cif.all_clear & ~cif.dac_clear;
      dac_regs_reset   <= cif.dac_clear;
    end
  end

endmodule

//--- verilog/phr_rst_seq.sv
// Purpose: sequences software and hardware reset into clear pulses
// Assumes: hw_low is synchronised, active while the pin is low
// Notes:   hardware reset holds clear for as long as the pin is low
`timescale 1ns/1ns
module phr_rst_seq
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  input  wire logic   ce,
  phr_ctrl_if.rstctl  bus
);

  phr_pkg::phr_rst_state_t state_q;

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // hardware reset wins over software reset
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= phr_pkg::PHR_RUN;
    else if (ce)
    begin
      case (state_q)
        phr_pkg::PHR_RUN,
        phr_pkg::PHR_SOFT,
        phr_pkg::PHR_HARD:
        begin
          if (bus.hw_low)
            state_q <= phr_pkg::PHR_HARD;
          else if (bus.soft_hit)
            state_q <= phr_pkg::PHR_SOFT;
          else
            state_q <= phr_pkg::PHR_RUN;
        end
        default:
          state_q <= phr_pkg::PHR_RUN;
      endcase
    end
  end

  // clear outputs decoded from one-hot state
  assign bus.all_clear = (state_q != phr_pkg::PHR_RUN);
  assign bus.dac_clear = (state_q == phr_pkg::PHR_HARD);

endmodule

//--- verilog/phr_srst_decode.sv
// Purpose: recognises a software reset write
// Assumes: i2c_mode already synchronised
// Notes:   purely combinational
`timescale 1ns/1ns
module phr_srst_decode
(
  phr_ctrl_if.decode bus
);

  // key check differs per serial mode
  always_comb
  begin
    bus.soft_hit = 1'b0;
    if (bus.wr_en && (bus.addr == phr_pkg::OFF_SRST))
    begin
      if (bus.i2c_mode)
        bus.soft_hit = 1'b1;
      else
        bus.soft_hit = (bus.wdata == phr_pkg::SRST_SPI_KEY);
    end
  end

endmodule
